// *** src/tcpbg_pkg.sv ***
package tcpbg_pkg;
    // ************************************************************
    // Register indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_CONTROL   = 8'h88;
    localparam logic [7:0] IDX_MODE      = 8'h89;
    localparam logic [7:0] IDX_T0LOW     = 8'h8a;
    localparam logic [7:0] IDX_T1LOW     = 8'h8b;
    localparam logic [7:0] IDX_T0HIGH    = 8'h8c;
    localparam logic [7:0] IDX_T1HIGH    = 8'h8d;
    localparam logic [7:0] IDX_T2CTRL    = 8'hc8;
    localparam logic [7:0] IDX_T2RELLOW  = 8'hca;
    localparam logic [7:0] IDX_T2RELHIGH = 8'hcb;
    localparam logic [7:0] IDX_T2LOW     = 8'hcc;
    localparam logic [7:0] IDX_T2HIGH    = 8'hcd;
    localparam logic [7:0] IDX_IRQSTAT   = 8'hd0;
    localparam logic [7:0] IDX_IRQMASK   = 8'hd1;
    localparam logic [7:0] IDX_CLKCFG    = 8'hd2;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MODE_GATE0  = 3;
    localparam int MODE_CT0    = 2;
    localparam int MODE_MLO0   = 0;
    localparam int MODE_GATE1  = 7;
    localparam int MODE_CT1    = 6;
    localparam int MODE_MLO1   = 4;
    localparam int CTRL_RUN0   = 4;
    localparam int CTRL_OVF0   = 5;
    localparam int CTRL_RUN1   = 6;
    localparam int CTRL_OVF1   = 7;
    localparam int T2_RUN      = 2;
    localparam int T2_EXTEN    = 3;
    localparam int T2_TXSEL    = 4;
    localparam int T2_RXSEL    = 5;
    localparam int T2_EXTFLAG  = 6;
    localparam int T2_OVF      = 7;
    localparam int CFG_SIXT    = 0;
    // Interrupt status bits
    localparam int IRQ_OVF0    = 0;
    localparam int IRQ_OVF1    = 1;
    localparam int IRQ_EXTEDGE = 2;
    localparam int IRQ_BAUD    = 3;
    // ************************************************************
    // Reset values and timing counts
    // ************************************************************
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [2:0] TICK_DIV     = 3'h6;
    localparam logic [1:0] MODE_13BIT   = 2'h0;
    localparam logic [1:0] MODE_16BIT   = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_HALT    = 2'h3;
endpackage : tcpbg_pkg

// *** src/tcpbg_counter.sv ***
`timescale 1ns/1ps
module tcpbg_counter (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire logic       tick,
    input  wire logic       countSel,
    input  wire logic       pinSync,
    input  wire logic       runBit,
    input  wire logic       gateCtl,
    input  wire logic       gatePin,
    input  wire logic [1:0] modeField,
    input  wire logic       haltMode3,
    input  wire logic       wrLow,
    input  wire logic       wrHigh,
    input  wire logic [7:0] wrData,
    output logic      [7:0] countLow,
    output logic      [7:0] countHigh,
    output logic            overflow
);
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       pinPrev;
        logic       ovf;
    } tcpbg_cnt_s;
    tcpbg_cnt_s state_reg;
    tcpbg_cnt_s state_next;
    logic       advance;
    logic       incr;
    logic [12:0] c13;
    logic [15:0] c16;

    always_comb begin
        state_next = state_reg;
        state_next.ovf = 1'b0;
        incr = 1'b0;
        c13 = {state_reg.high, state_reg.low[4:0]};
        c16 = {state_reg.high, state_reg.low};
        advance = runBit && (!gateCtl || gatePin);
        if (tick) begin
            state_next.pinPrev = pinSync;
            incr = countSel ? (state_reg.pinPrev && !pinSync) : 1'b1;
        end
        if (advance && incr && !(haltMode3 && modeField == tcpbg_pkg::MODE_HALT)) begin
            case (modeField)
                tcpbg_pkg::MODE_13BIT: begin
                    c13 = c13 + 13'h0001;
                    state_next.high = c13[12:5];
                    state_next.low = {state_reg.low[7:5], c13[4:0]};
                    state_next.ovf = (c13 == 13'h0000);
                end
                tcpbg_pkg::MODE_16BIT: begin
                    c16 = c16 + 16'h0001;
                    state_next.high = c16[15:8];
                    state_next.low = c16[7:0];
                    state_next.ovf = (c16 == 16'h0000);
                end
                tcpbg_pkg::MODE_RELOAD8: begin
                    if (state_reg.low == 8'hff) begin
                        state_next.low = state_reg.high;
                        state_next.ovf = 1'b1;
                    end else begin
                        state_next.low = state_reg.low + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wrLow) begin
            state_next.low = wrData;
        end
        if (wrHigh) begin
            state_next.high = wrData;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign countLow  = state_reg.low;
    assign countHigh = state_reg.high;
    assign overflow  = state_reg.ovf;
endmodule : tcpbg_counter

// *** src/tcpbg_timers.sv ***
`timescale 1ns/1ps
// How it works
// - Two counters, each a high and low byte forming sixteen bits
// - Mode bit 2 selects counter 0 source, bit 6 counter 1
// - Select 0 counts internal ticks, 1 counts count pin falling edges
// - Timer ticks at one sixth of the peripheral clock
// - Pin sampled once per machine cycle; high then low counts
// - Counts only when run set and gate off or gate pin high
// - Mode field: 13-bit, 16-bit, 8-bit reload, counter 1 halt
// - Mode 0 uses high byte and five low bits of low byte
// - Mode 0 wrap sets overflow flag and may interrupt
// - Peripheral clock is half oscillator in 12T, full in 6T
// - Third timer becomes baud generator when either clock select set
// - Baud mode: 16-bit auto-reload, rollover gives shift clock and baud status bit, no overflow flag
// - Baud mode with edge enable: capture pin fall sets external flag
// - Transmit and receive clock sources chosen independently
module tcpbg_timers (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        countPin0,
    input  wire logic        countPin1,
    input  wire logic        gatePin0,
    input  wire logic        gatePin1,
    input  wire logic        capturePin,
    output logic             txShiftClk,
    output logic             rxShiftClk,
    output logic             irq
);
    typedef struct packed {
        logic [2:0]  pinSync1;
        logic [2:0]  pinSync2;
        logic [1:0]  gateSync1;
        logic [1:0]  gateSync2;
        logic        halfPhase;
        logic [2:0]  divCnt;
        logic [7:0]  modeSel;
        logic [7:0]  ctrl;
        logic [7:0]  t2ctrl;
        logic [15:0] t2count;
        logic [15:0] t2reload;
        logic        capPrev;
        logic        sixT;
        logic [3:0]  irqStat;
        logic [3:0]  irqMask;
        logic        t1Ovf;
        logic        txClk;
        logic        rxClk;
        logic [31:0] rdata;
    } tcpbg_top_s;
    tcpbg_top_s st_reg;
    tcpbg_top_s st_next;

    logic        access;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  idx;
    logic        mapped;
    logic        periphEn;
    logic        tick;
    logic [7:0]  low0;
    logic [7:0]  high0;
    logic [7:0]  low1;
    logic [7:0]  high1;
    logic        ovf0;
    logic        ovf1;
    logic        baudMode;
    logic        t2roll;
    logic        capFall;
    logic [7:0]  rd;
    logic [7:0]  ctrlView;

    assign access = psel && penable;
    assign idx    = paddr[9:2];
    assign wrEn   = access && pwrite && clkEn;
    assign rdEn   = access && !pwrite && clkEn;

    // ************************************************************
    // Peripheral clock and timer tick
    // ************************************************************
    // half rate unless six-clock mode
    assign periphEn = st_reg.sixT || st_reg.halfPhase;
    assign tick = periphEn && (st_reg.divCnt == tcpbg_pkg::TICK_DIV - 3'h1);

    // ************************************************************
    // Counters 0 and 1
    // ************************************************************
    // two counter instances
    tcpbg_counter u_cnt0 (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clkEn     (clkEn),
        .tick      (tick),
        .countSel  (st_reg.modeSel[tcpbg_pkg::MODE_CT0]),
        .pinSync   (st_reg.pinSync2[0]),
        .runBit    (st_reg.ctrl[tcpbg_pkg::CTRL_RUN0]),
        .gateCtl   (st_reg.modeSel[tcpbg_pkg::MODE_GATE0]),
        .gatePin   (st_reg.gateSync2[0]),
        .modeField (st_reg.modeSel[tcpbg_pkg::MODE_MLO0 +: 2]),
        .haltMode3 (1'b0),
        .wrLow     (wrEn && idx == tcpbg_pkg::IDX_T0LOW),
        .wrHigh    (wrEn && idx == tcpbg_pkg::IDX_T0HIGH),
        .wrData    (pwdata[7:0]),
        .countLow  (low0),
        .countHigh (high0),
        .overflow  (ovf0)
    );
    tcpbg_counter u_cnt1 (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clkEn     (clkEn),
        .tick      (tick),
        .countSel  (st_reg.modeSel[tcpbg_pkg::MODE_CT1]),
        .pinSync   (st_reg.pinSync2[1]),
        .runBit    (st_reg.ctrl[tcpbg_pkg::CTRL_RUN1]),
        .gateCtl   (st_reg.modeSel[tcpbg_pkg::MODE_GATE1]),
        .gatePin   (st_reg.gateSync2[1]),
        .modeField (st_reg.modeSel[tcpbg_pkg::MODE_MLO1 +: 2]),
        .haltMode3 (1'b1),
        .wrLow     (wrEn && idx == tcpbg_pkg::IDX_T1LOW),
        .wrHigh    (wrEn && idx == tcpbg_pkg::IDX_T1HIGH),
        .wrData    (pwdata[7:0]),
        .countLow  (low1),
        .countHigh (high1),
        .overflow  (ovf1)
    );

    // ************************************************************
    // Third timer in baud generator mode
    // ************************************************************
    // either select enters baud mode
    assign baudMode = st_reg.t2ctrl[tcpbg_pkg::T2_TXSEL] || st_reg.t2ctrl[tcpbg_pkg::T2_RXSEL];
    // Counts peripheral clocks, not the divided tick, as baud timers do
    assign t2roll = baudMode && st_reg.t2ctrl[tcpbg_pkg::T2_RUN] && periphEn
                    && st_reg.t2count == 16'hffff;
    // Edge seen on the second sync stage only
    assign capFall = st_reg.capPrev && !st_reg.pinSync2[2];

    assign ctrlView = st_reg.ctrl;

    always_comb begin
        st_next = st_reg;
        st_next.pinSync1  = {capturePin, countPin1, countPin0};
        st_next.pinSync2  = st_reg.pinSync1;
        st_next.gateSync1 = {gatePin1, gatePin0};
        st_next.gateSync2 = st_reg.gateSync1;
        st_next.capPrev   = st_reg.pinSync2[2];
        st_next.halfPhase = !st_reg.halfPhase;
        st_next.t1Ovf     = ovf1;
        st_next.txClk     = 1'b0;
        st_next.rxClk     = 1'b0;
        if (periphEn) begin
            st_next.divCnt = tick ? 3'h0 : st_reg.divCnt + 3'h1;
        end
        if (baudMode && st_reg.t2ctrl[tcpbg_pkg::T2_RUN] && periphEn) begin
            st_next.t2count = t2roll ? st_reg.t2reload : st_reg.t2count + 16'h0001;
        end
        st_next.txClk = st_reg.t2ctrl[tcpbg_pkg::T2_TXSEL] ? t2roll : st_reg.t1Ovf;
        st_next.rxClk = st_reg.t2ctrl[tcpbg_pkg::T2_RXSEL] ? t2roll : st_reg.t1Ovf;
        // Register writes come first so hardware sets win below
        if (wrEn) begin
            case (idx)
                tcpbg_pkg::IDX_MODE:      st_next.modeSel = pwdata[7:0];
                tcpbg_pkg::IDX_CONTROL:   st_next.ctrl = pwdata[7:0];
                tcpbg_pkg::IDX_T2CTRL:    st_next.t2ctrl = pwdata[7:0];
                tcpbg_pkg::IDX_T2RELLOW:  st_next.t2reload[7:0] = pwdata[7:0];
                tcpbg_pkg::IDX_T2RELHIGH: st_next.t2reload[15:8] = pwdata[7:0];
                tcpbg_pkg::IDX_T2LOW:     st_next.t2count[7:0] = pwdata[7:0];
                tcpbg_pkg::IDX_T2HIGH:    st_next.t2count[15:8] = pwdata[7:0];
                tcpbg_pkg::IDX_IRQMASK:   st_next.irqMask = pwdata[3:0];
                tcpbg_pkg::IDX_CLKCFG:    st_next.sixT = pwdata[tcpbg_pkg::CFG_SIXT];
                default: begin
                end
            endcase
        end
        // Read clears only the bits it reported; a later event still lands
        if (rdEn && idx == tcpbg_pkg::IDX_IRQSTAT) begin
            st_next.irqStat = st_reg.irqStat & ~st_reg.rdata[3:0];
        end
        if (ovf0) begin
            st_next.ctrl[tcpbg_pkg::CTRL_OVF0] = 1'b1;
            st_next.irqStat[tcpbg_pkg::IRQ_OVF0] = 1'b1;
        end
        if (ovf1) begin
            st_next.ctrl[tcpbg_pkg::CTRL_OVF1] = 1'b1;
            st_next.irqStat[tcpbg_pkg::IRQ_OVF1] = 1'b1;
        end
        if (baudMode && st_reg.t2ctrl[tcpbg_pkg::T2_EXTEN] && capFall) begin
            st_next.t2ctrl[tcpbg_pkg::T2_EXTFLAG] = 1'b1;
            st_next.irqStat[tcpbg_pkg::IRQ_EXTEDGE] = 1'b1;
        end
        if (t2roll) begin
            st_next.irqStat[tcpbg_pkg::IRQ_BAUD] = 1'b1;
        end
        case (idx)
            tcpbg_pkg::IDX_MODE:      rd = st_reg.modeSel;
            tcpbg_pkg::IDX_CONTROL:   rd = ctrlView;
            tcpbg_pkg::IDX_T0LOW:     rd = low0;
            tcpbg_pkg::IDX_T0HIGH:    rd = high0;
            tcpbg_pkg::IDX_T1LOW:     rd = low1;
            tcpbg_pkg::IDX_T1HIGH:    rd = high1;
            tcpbg_pkg::IDX_T2CTRL:    rd = st_reg.t2ctrl;
            tcpbg_pkg::IDX_T2RELLOW:  rd = st_reg.t2reload[7:0];
            tcpbg_pkg::IDX_T2RELHIGH: rd = st_reg.t2reload[15:8];
            tcpbg_pkg::IDX_T2LOW:     rd = st_reg.t2count[7:0];
            tcpbg_pkg::IDX_T2HIGH:    rd = st_reg.t2count[15:8];
            tcpbg_pkg::IDX_IRQSTAT:   rd = {4'h0, st_reg.irqStat};
            tcpbg_pkg::IDX_IRQMASK:   rd = {4'h0, st_reg.irqMask};
            tcpbg_pkg::IDX_CLKCFG:    rd = {7'h00, st_reg.sixT};
            default:                  rd = 8'h00;
        endcase
        if (psel && !penable) begin
            st_next.rdata = {24'h000000, rd};
        end
    end

    always_comb begin
        case (idx)
            tcpbg_pkg::IDX_MODE, tcpbg_pkg::IDX_CONTROL, tcpbg_pkg::IDX_T0LOW,
            tcpbg_pkg::IDX_T0HIGH, tcpbg_pkg::IDX_T1LOW, tcpbg_pkg::IDX_T1HIGH,
            tcpbg_pkg::IDX_T2CTRL, tcpbg_pkg::IDX_T2RELLOW, tcpbg_pkg::IDX_T2RELHIGH,
            tcpbg_pkg::IDX_T2LOW, tcpbg_pkg::IDX_T2HIGH, tcpbg_pkg::IDX_IRQSTAT,
            tcpbg_pkg::IDX_IRQMASK, tcpbg_pkg::IDX_CLKCFG: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Bus answer and outputs
    // ************************************************************
    // Zero wait: read data is latched in the setup cycle
    assign pready     = clkEn;
    assign prdata     = st_reg.rdata;
    assign pslverr    = access && !mapped;
    assign txShiftClk = st_reg.txClk;
    assign rxShiftClk = st_reg.rxClk;
    assign irq        = |(st_reg.irqStat & st_reg.irqMask);
endmodule : tcpbg_timers

// *** verification/tcpbg_timers_properties.sv ***
`timescale 1ns/1ps
module tcpbg_timers_properties (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        clkEn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        txShiftClk,
    input wire logic        rxShiftClk,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [7:0] maskShadow;
    wire  [7:0] idx     = paddr[9:2];
    wire        maskWr  = psel && penable && pready && pwrite && idx == tcpbg_pkg::IDX_IRQMASK;
    wire        statAcc = psel && penable && idx == tcpbg_pkg::IDX_IRQSTAT;
    // Mask mirror lets irq be judged from the bus alone
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            maskShadow <= 8'h00;
        end else if (maskWr) begin
            maskShadow <= pwdata[7:0];
        end
    end
    sequence sUnmappedRd;
        psel && penable && !pwrite && idx == 8'h00;
    endsequence
    AST_PREADY_ZERO_WAIT: assert property (pready == clkEn)
        else $error("pready does not follow clkEn");
    AST_PRDATA_UPPER: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    AST_ERR_ONLY_ACCESS: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access phase");
    AST_MODE_MAPPED: assert property (psel && penable && idx == tcpbg_pkg::IDX_MODE |-> !pslverr)
        else $error("mode register refused");
    AST_UNMAPPED_READ: assert property (sUnmappedRd |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    AST_IRQ_MASKED: assert property (maskShadow == 8'h00 |-> !irq)
        else $error("irq high with every source masked");
    AST_IRQ_STICKY: assert property (irq && !statAcc && !maskWr |=> irq)
        else $error("irq dropped without status read");
    AST_FREEZE: assert property (!clkEn |=> $stable(irq) && $stable(txShiftClk) && $stable(rxShiftClk))
        else $error("outputs moved while clock enable low");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !irq && !txShiftClk && !rxShiftClk)
        else $error("outputs active right after reset");
endmodule : tcpbg_timers_properties

bind tcpbg_timers tcpbg_timers_properties u_props (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txShiftClk(txShiftClk), .rxShiftClk(rxShiftClk), .irq(irq)
);

// *** verification/tcpbg_pin_model.sv ***
`timescale 1ns/1ps
module tcpbg_pin_model (
    input  wire logic clk_sys,
    output logic      countPin0,
    output logic      countPin1,
    output logic      gatePin0,
    output logic      gatePin1,
    output logic      capturePin
);
    // Count and capture pins rest high: only a fall is an event
    initial begin
        countPin0 = 1'b1;
        countPin1 = 1'b1;
        gatePin0 = 1'b0;
        gatePin1 = 1'b0;
        capturePin = 1'b1;
    end
    task automatic drivePin(input int pin, input logic v);
        case (pin)
            0: countPin0 <= v;
            1: countPin1 <= v;
            default: capturePin <= v;
        endcase
    endtask : drivePin
    // Hold sets speed; long holds let two machine-cycle samples see each level
    task automatic fallPulses(input int pin, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            repeat (hold) @(posedge clk_sys);
            drivePin(pin, 1'b0);
            repeat (hold) @(posedge clk_sys);
            drivePin(pin, 1'b1);
        end
    endtask : fallPulses
    task automatic setGate(input logic g0, input logic g1);
        gatePin0 <= g0;
        gatePin1 <= g1;
    endtask : setGate
endmodule : tcpbg_pin_model

// *** verification/timer_counter_pair_with_baud_gen_tb.sv ***
`timescale 1ns/1ps
module timer_counter_pair_with_baud_gen_tb;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        clkEn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, txShiftClk, rxShiftClk, irq, rdErr;
    logic        countPin0, countPin1, gatePin0, gatePin1, capturePin;
    int          mismatches = 0;
    int          n_checks = 0;
    int          txCount = 0;
    int          rxCount = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (txShiftClk === 1'b1) txCount <= txCount + 1;
        if (rxShiftClk === 1'b1) rxCount <= rxCount + 1;
    end
    tcpbg_timers u_tcpbg_timers (
        .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .countPin0(countPin0), .countPin1(countPin1),
        .gatePin0(gatePin0), .gatePin1(gatePin1), .capturePin(capturePin),
        .txShiftClk(txShiftClk), .rxShiftClk(rxShiftClk), .irq(irq)
    );
    tcpbg_pin_model u_tcpbg_pin_model (
        .clk_sys(clk_sys), .countPin0(countPin0), .countPin1(countPin1),
        .gatePin0(gatePin0), .gatePin1(gatePin1), .capturePin(capturePin)
    );
    // ******************************
    // Bus and compare helpers
    // ******************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic inRange(input logic [31:0] v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : inRange
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            mismatches++;
            results();
        end
        rdv = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        apb(idx, 1'b0, 8'h00);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    // ******************************
    // Scenarios
    // ******************************
    task automatic tReset;
        logic [7:0] ids [5];
        ids = '{tcpbg_pkg::IDX_MODE, tcpbg_pkg::IDX_T1LOW, tcpbg_pkg::IDX_T1HIGH,
                tcpbg_pkg::IDX_CONTROL, tcpbg_pkg::IDX_IRQMASK};
        foreach (ids[i]) begin
            rd(ids[i]);
            check(rdv, 32'h0);
        end
        rd(8'h00);
        check({31'h0, rdErr}, 32'h1);
        $display("tReset done");
    endtask : tReset
    task automatic tRegs;
        wr(tcpbg_pkg::IDX_MODE, 8'ha5);
        wr(tcpbg_pkg::IDX_T1LOW, 8'h3c);
        wr(tcpbg_pkg::IDX_T1HIGH, 8'hc3);
        rd(tcpbg_pkg::IDX_MODE);
        check(rdv, 32'ha5);
        rd(tcpbg_pkg::IDX_T1LOW);
        check(rdv, 32'h3c);
        rd(tcpbg_pkg::IDX_T1HIGH);
        check(rdv, 32'hc3);
        $display("tRegs done");
    endtask : tRegs
    task automatic tTimer;
        wr(tcpbg_pkg::IDX_MODE, 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr(tcpbg_pkg::IDX_CLKCFG, s[7:0]);
            wr(tcpbg_pkg::IDX_T0LOW, 8'h00);
            wr(tcpbg_pkg::IDX_CONTROL, 8'h10);
            cyc(s == 1 ? 60 : 120);
            // Short freeze: about one tick of slack allowed for it
            clkEn <= 1'b0;
            cyc(4);
            clkEn <= 1'b1;
            rd(tcpbg_pkg::IDX_T0LOW);
            inRange(rdv, 9, 12);
            wr(tcpbg_pkg::IDX_CONTROL, 8'h00);
        end
        $display("tTimer done");
    endtask : tTimer
    task automatic tGate;
        wr(tcpbg_pkg::IDX_MODE, 8'h09);
        wr(tcpbg_pkg::IDX_T0LOW, 8'h00);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h10);
        cyc(60);
        rd(tcpbg_pkg::IDX_T0LOW);
        check(rdv, 32'h0);
        u_tcpbg_pin_model.setGate(1'b1, 1'b0);
        cyc(60);
        rd(tcpbg_pkg::IDX_T0LOW);
        inRange(rdv, 8, 12);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h00);
        $display("tGate done");
    endtask : tGate
    task automatic tPin;
        wr(tcpbg_pkg::IDX_MODE, 8'h55);
        wr(tcpbg_pkg::IDX_T0LOW, 8'h00);
        wr(tcpbg_pkg::IDX_T1LOW, 8'h00);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h50);
        u_tcpbg_pin_model.fallPulses(0, 3, 16);
        u_tcpbg_pin_model.fallPulses(1, 5, 16);
        cyc(20);
        rd(tcpbg_pkg::IDX_T0LOW);
        check(rdv, 32'h3);
        rd(tcpbg_pkg::IDX_T1LOW);
        check(rdv, 32'h5);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h00);
        $display("tPin done");
    endtask : tPin
    task automatic tWrap;
        for (int m = 0; m < 2; m++) begin
            wr(tcpbg_pkg::IDX_MODE, m[7:0]);
            wr(tcpbg_pkg::IDX_T0HIGH, 8'hff);
            wr(tcpbg_pkg::IDX_T0LOW, m == 0 ? 8'hbf : 8'hff);
            wr(tcpbg_pkg::IDX_IRQMASK, 8'h00);
            wr(tcpbg_pkg::IDX_CONTROL, 8'h10);
            cyc(30);
            check({31'h0, irq}, 32'h0);
            rd(tcpbg_pkg::IDX_T0HIGH);
            check(rdv, 32'h0);
            rd(tcpbg_pkg::IDX_CONTROL);
            check({31'h0, rdv[tcpbg_pkg::CTRL_OVF0]}, 32'h1);
            wr(tcpbg_pkg::IDX_IRQMASK, 8'h01);
            cyc(1);
            check({31'h0, irq}, 32'h1);
            rd(tcpbg_pkg::IDX_IRQSTAT);
            check({31'h0, rdv[tcpbg_pkg::IRQ_OVF0]}, 32'h1);
            cyc(1);
            check({31'h0, irq}, 32'h0);
            wr(tcpbg_pkg::IDX_CONTROL, 8'h00);
        end
        $display("tWrap done");
    endtask : tWrap
    task automatic tReload;
        logic [31:0] held;
        wr(tcpbg_pkg::IDX_MODE, 8'h20);
        wr(tcpbg_pkg::IDX_T1HIGH, 8'hf0);
        wr(tcpbg_pkg::IDX_T1LOW, 8'hfe);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h40);
        cyc(36);
        rd(tcpbg_pkg::IDX_T1LOW);
        inRange(rdv, 'hf2, 'hf6);
        rd(tcpbg_pkg::IDX_T1HIGH);
        check(rdv, 32'hf0);
        wr(tcpbg_pkg::IDX_MODE, 8'h30);
        rd(tcpbg_pkg::IDX_T1LOW);
        held = rdv;
        cyc(60);
        rd(tcpbg_pkg::IDX_T1LOW);
        check(rdv, held);
        wr(tcpbg_pkg::IDX_CONTROL, 8'h00);
        $display("tReload done");
    endtask : tReload
    task automatic tBaud;
        int tx0, rx0;
        logic [7:0] sel [2];
        sel = '{8'h14, 8'h24};
        wr(tcpbg_pkg::IDX_T2RELLOW, 8'hf0);
        wr(tcpbg_pkg::IDX_T2RELHIGH, 8'hff);
        wr(tcpbg_pkg::IDX_T2LOW, 8'hf0);
        wr(tcpbg_pkg::IDX_T2HIGH, 8'hff);
        foreach (sel[i]) begin
            wr(tcpbg_pkg::IDX_T2CTRL, sel[i]);
            // Drain a pulse of the old source
            cyc(2);
            tx0 = txCount;
            rx0 = rxCount;
            cyc(160);
            inRange(i == 0 ? txCount - tx0 : rxCount - rx0, 9, 11);
            check(i == 0 ? rxCount - rx0 : txCount - tx0, 32'h0);
            rd(tcpbg_pkg::IDX_T2CTRL);
            check({31'h0, rdv[tcpbg_pkg::T2_OVF]}, 32'h0);
        end
        wr(tcpbg_pkg::IDX_IRQMASK, 8'h04);
        wr(tcpbg_pkg::IDX_T2CTRL, 8'h2c);
        u_tcpbg_pin_model.fallPulses(2, 1, 16);
        cyc(6);
        check({31'h0, irq}, 32'h1);
        rd(tcpbg_pkg::IDX_T2CTRL);
        check({31'h0, rdv[tcpbg_pkg::T2_EXTFLAG]}, 32'h1);
        rd(tcpbg_pkg::IDX_IRQSTAT);
        check({31'h0, rdv[tcpbg_pkg::IRQ_EXTEDGE]}, 32'h1);
        wr(tcpbg_pkg::IDX_T2CTRL, 8'h00);
        $display("tBaud done");
    endtask : tBaud
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        tReset();
        tRegs();
        tTimer();
        tGate();
        tPin();
        tWrap();
        tReload();
        tBaud();
        results();
    end
endmodule : timer_counter_pair_with_baud_gen_tb
